// ### logic/rss_consts.svh
// Behaviour
// - Frequency sweep runs only while the reference source is internal sweep.
// - Linear frequency sweep adds the step frequency to the previous frequency.
// - Log frequency sweep adds step percent of the previous frequency.
// - Start and stop frequency accepted from 1 mHz to 102 kHz, 1 mHz resolution.
// - After reset the frequency sweep starts at 1 kHz and stops at 5 kHz.
// - Log frequency step percentage has 0.001 percent resolution.
// - Each frequency step is held for a dwell time of 1 ms to 100 s.
// - Single frequency sweep runs once then returns the run state to stop.
// - Loop sweeps restart from start after each pass until stopped.
// - Two independent harmonic orders are kept and used at the same time.
// - Each harmonic order is limited to 1 through 32767.
// - An order whose product with the reference reaches 102 kHz is lowered.
// - An order written as zero becomes one; reset order is one.
// - Amplitude sweep is fixed, linear or log; fixed after reset uses user value.
// - Fixed amplitude is settable from 1 mVrms to 5 Vrms in 1 mVrms steps.
// - External reference locks the output; internal uses the oscillator.
// - A logic-level square output runs in step with the sine output; under external reference ttl_o follows the synced pin.
// - Linear amplitude step is absolute; log step is percent of present value.
// - Amplitude sweep resets to start 1 V and stop 5 V, within 1 mV to 5 V.
// - Log amplitude step has 0.001 percent resolution; dwell 1 ms to 100000 ms.
// - Single amplitude sweep runs once then returns the run state to stop.
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// Register byte offsets
`define RSS_A_CTRL     8'h00
`define RSS_A_REFF     8'h04
`define RSS_A_FSTART   8'h08
`define RSS_A_FSTOP    8'h0C
`define RSS_A_FSTEP    8'h10
`define RSS_A_FDWELL   8'h14
`define RSS_A_AFIX     8'h18
`define RSS_A_ASTART   8'h1C
`define RSS_A_ASTOP    8'h20
`define RSS_A_ASTEP    8'h24
`define RSS_A_ADWELL   8'h28
`define RSS_A_HARM1    8'h2C
`define RSS_A_HARM2    8'h30
`define RSS_A_RUN      8'h34
`define RSS_A_FREQNOW  8'h38
`define RSS_A_AMPNOW   8'h3C
`define RSS_A_HEFF     8'h40

// Field positions
`define RSS_F_SRC      1:0
`define RSS_F_FLOG     2
`define RSS_F_ATYPE    4:3
`define RSS_F_FRUN     1:0
`define RSS_F_ARUN     3:2

// Limits, frequency in mHz, amplitude in mVrms, dwell in ms, step pct in 0.001 %
`define RSS_FREQ_MIN   27'h000_0001
`define RSS_FREQ_MAX   27'h614_6580
`define RSS_AMP_MIN    27'h000_0001
`define RSS_AMP_MAX    27'h000_1388
`define RSS_DWELL_MIN  17'h0_0001
`define RSS_DWELL_MAX  17'h1_86A0
`define RSS_PCT_DEN    27'h001_86A0
`define RSS_HARM_MAX   15'h7FFF

// Reset values
`define RSS_RST_FSTART 27'h00F_4240
`define RSS_RST_FSTOP  27'h04C_4B40
`define RSS_RST_FSTEP  27'h001_86A0
`define RSS_RST_ASTART 27'h000_03E8
`define RSS_RST_ASTOP  27'h000_1388
`define RSS_RST_ASTEP  27'h000_0064
`define RSS_RST_AFIX   27'h000_03E8
`define RSS_RST_DWELL  17'h0_0064
`define RSS_RST_REFF   27'h00F_4240

// Timing: clock rate in Hz, dwell tick in ms
`define RSS_CLK_HZ     250000000
`define RSS_TICK_MS    1
`define RSS_TICK_CYC   (`RSS_CLK_HZ / 1000 * `RSS_TICK_MS)
// Phase increment scale: 2^52 / (clock Hz * 1000), used with a 20-bit right shift
`define RSS_NCO_K      15'h465E

`endif

// ### logic/rss_pkg.sv
`default_nettype none
package rss_pkg;
   typedef enum logic [1:0] {
      RSS_SRC_EXT   = 2'h0,
      RSS_SRC_INT   = 2'h1,
      RSS_SRC_SWEEP = 2'h2,
      RSS_SRC_RSVD  = 2'h3
   } rss_src_t;

   typedef enum logic [1:0] {
      RSS_AT_FIXED = 2'h0,
      RSS_AT_LIN   = 2'h1,
      RSS_AT_LOG   = 2'h2,
      RSS_AT_RSVD  = 2'h3
   } rss_atype_t;

   typedef enum logic [1:0] {
      RSS_RUN_STOP   = 2'h0,
      RSS_RUN_SINGLE = 2'h1,
      RSS_RUN_LOOP   = 2'h2,
      RSS_RUN_RSVD   = 2'h3
   } rss_run_t;

   typedef enum logic [1:0] {
      RSS_ST_IDLE  = 2'b01,
      RSS_ST_DWELL = 2'b10
   } rss_st_t;

   typedef struct packed {
      logic [26:0] start;
      logic [26:0] stop;
      logic [26:0] step;
      logic [16:0] dwell;
   } rss_swcfg_t;
endpackage : rss_pkg
`default_nettype wire

// ### logic/rss_top.sv
`include "rss_consts.svh"
`default_nettype none
module rss_top #(
   parameter int TICK_CYC = `RSS_TICK_CYC
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        ext_ref_i,
   input  wire logic [26:0] ext_freq_i,
   output logic      [26:0] freq_o,
   output logic      [12:0] amp_o,
   output logic      [14:0] harm1_o,
   output logic      [14:0] harm2_o,
   output logic             ext_lock_o,
   output logic             ttl_o,
   output logic      [15:0] phase_o
);
   if (TICK_CYC < 2) begin : g_bad_tick
      $error("TICK_CYC must be at least 2");
   end

   // Configuration state
   rss_pkg::rss_src_t   src_r;
   rss_pkg::rss_atype_t atype_r;
   logic                flog_r;
   logic [26:0]         reff_r;
   logic [26:0]         afix_r;
   rss_pkg::rss_swcfg_t cfg_r   [2];
   logic [14:0]         hset_r  [2];
   logic [14:0]         heff_r  [2];
   // Sweep state, index 0 frequency, 1 amplitude
   rss_pkg::rss_run_t   run_r   [2];
   rss_pkg::rss_st_t    st_r    [2];
   logic [26:0]         cur_r   [2];
   logic [16:0]         cnt_r   [2];
   logic                en      [2];
   logic                logm    [2];
   // Bus state
   logic                dp_wr_r;
   logic                dp_rd_r;
   logic [7:0]          dp_addr_r;
   logic                run_wr;
   logic [31:0]         rd_mux;
   logic                aphase;
   // Timing and oscillator
   logic [31:0]         tick_cnt_r;
   logic                tick_r;
   logic [2:0]          ref_sync_r;
   logic                ref_lvl_r;
   logic [31:0]         phase_r;
   logic [41:0]         inc_prod;

   function automatic logic [26:0] clamp27(input logic [31:0] v, input logic [26:0] lo,
                                           input logic [26:0] hi);
      if (v < {5'h00, lo}) begin
         clamp27 = lo;
      end else if (v > {5'h00, hi}) begin
         clamp27 = hi;
      end else begin
         clamp27 = v[26:0];
      end
   endfunction : clamp27

   function automatic logic [16:0] clamp_dw(input logic [31:0] v);
      if (v < {15'h0000, `RSS_DWELL_MIN}) begin
         clamp_dw = `RSS_DWELL_MIN;
      end else if (v > {15'h0000, `RSS_DWELL_MAX}) begin
         clamp_dw = `RSS_DWELL_MAX;
      end else begin
         clamp_dw = v[16:0];
      end
   endfunction : clamp_dw

   function automatic logic [14:0] harm_in(input logic [31:0] v);
      if (v == 32'h0000_0000) begin
         harm_in = 15'h0001;
      end else if (v > {17'h0_0000, `RSS_HARM_MAX}) begin
         harm_in = `RSS_HARM_MAX;
      end else begin
         harm_in = v[14:0];
      end
   endfunction : harm_in

   // AHB-Lite address phase; only the low byte decodes, words only
   assign aphase = hsel & hready & htrans[1];
   assign hresp  = 1'b0;
   assign run_wr = dp_wr_r & (dp_addr_r == `RSS_A_RUN);

   // Data phase tracking; reads take one wait state so they see a write just before
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_r   <= 1'b0;
         dp_rd_r   <= 1'b0;
         dp_addr_r <= 8'h00;
         hreadyout <= 1'b1;
         hrdata    <= 32'h0000_0000;
      end else begin
         if (hready) begin
            dp_wr_r   <= aphase & hwrite;
            dp_rd_r   <= aphase & ~hwrite;
            dp_addr_r <= {haddr[7:2], 2'b00};
            if (aphase & ~hwrite) begin
               hreadyout <= 1'b0;
            end
         end else if (dp_rd_r & ~hreadyout) begin
            hrdata    <= rd_mux;
            hreadyout <= 1'b1;
         end
      end
   end

   // Register writes; out-of-range values are clamped rather than refused
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_r     <= rss_pkg::RSS_SRC_EXT;
         atype_r   <= rss_pkg::RSS_AT_FIXED;
         flog_r    <= 1'b0;
         reff_r    <= `RSS_RST_REFF;
         afix_r    <= `RSS_RST_AFIX;
         cfg_r[0]  <= '{`RSS_RST_FSTART, `RSS_RST_FSTOP, `RSS_RST_FSTEP,
                        `RSS_RST_DWELL};
         cfg_r[1]  <= '{`RSS_RST_ASTART, `RSS_RST_ASTOP, `RSS_RST_ASTEP,
                        `RSS_RST_DWELL};
         hset_r[0] <= 15'h0001;
         hset_r[1] <= 15'h0001;
      end else if (dp_wr_r) begin
         unique case (dp_addr_r)
            `RSS_A_CTRL: begin
               src_r   <= rss_pkg::rss_src_t'(hwdata[`RSS_F_SRC]);
               flog_r  <= hwdata[`RSS_F_FLOG];
               atype_r <= rss_pkg::rss_atype_t'(hwdata[`RSS_F_ATYPE]);
            end
            `RSS_A_REFF:   reff_r          <= clamp27(hwdata, `RSS_FREQ_MIN, `RSS_FREQ_MAX);
            `RSS_A_FSTART: cfg_r[0].start  <= clamp27(hwdata, `RSS_FREQ_MIN, `RSS_FREQ_MAX);
            `RSS_A_FSTOP:  cfg_r[0].stop   <= clamp27(hwdata, `RSS_FREQ_MIN, `RSS_FREQ_MAX);
            `RSS_A_FSTEP:  cfg_r[0].step   <= hwdata[26:0];
            `RSS_A_FDWELL: cfg_r[0].dwell  <= clamp_dw(hwdata);
            `RSS_A_AFIX:   afix_r          <= clamp27(hwdata, `RSS_AMP_MIN, `RSS_AMP_MAX);
            `RSS_A_ASTART: cfg_r[1].start  <= clamp27(hwdata, `RSS_AMP_MIN, `RSS_AMP_MAX);
            `RSS_A_ASTOP:  cfg_r[1].stop   <= clamp27(hwdata, `RSS_AMP_MIN, `RSS_AMP_MAX);
            `RSS_A_ASTEP:  cfg_r[1].step   <= hwdata[26:0];
            `RSS_A_ADWELL: cfg_r[1].dwell  <= clamp_dw(hwdata);
            `RSS_A_HARM1:  hset_r[0]       <= harm_in(hwdata);
            `RSS_A_HARM2:  hset_r[1]       <= harm_in(hwdata);
            default: begin
            end
         endcase
      end
   end

   // Read decode; unmapped offsets read as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (dp_addr_r)
         `RSS_A_CTRL:    rd_mux = {27'h000_0000, atype_r, flog_r, src_r};
         `RSS_A_REFF:    rd_mux = {5'h00, reff_r};
         `RSS_A_FSTART:  rd_mux = {5'h00, cfg_r[0].start};
         `RSS_A_FSTOP:   rd_mux = {5'h00, cfg_r[0].stop};
         `RSS_A_FSTEP:   rd_mux = {5'h00, cfg_r[0].step};
         `RSS_A_FDWELL:  rd_mux = {15'h0000, cfg_r[0].dwell};
         `RSS_A_AFIX:    rd_mux = {5'h00, afix_r};
         `RSS_A_ASTART:  rd_mux = {5'h00, cfg_r[1].start};
         `RSS_A_ASTOP:   rd_mux = {5'h00, cfg_r[1].stop};
         `RSS_A_ASTEP:   rd_mux = {5'h00, cfg_r[1].step};
         `RSS_A_ADWELL:  rd_mux = {15'h0000, cfg_r[1].dwell};
         `RSS_A_HARM1:   rd_mux = {17'h0_0000, hset_r[0]};
         `RSS_A_HARM2:   rd_mux = {17'h0_0000, hset_r[1]};
         `RSS_A_RUN:     rd_mux = {28'h000_0000, run_r[1], run_r[0]};
         `RSS_A_FREQNOW: rd_mux = {5'h00, freq_o};
         `RSS_A_AMPNOW:  rd_mux = {19'h0_0000, amp_o};
         `RSS_A_HEFF:    rd_mux = {1'b0, heff_r[1], 1'b0, heff_r[0]};
         default:        rd_mux = 32'h0000_0000;
      endcase
   end

   // Millisecond tick enable for the dwell counters
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_r <= 32'h0000_0000;
         tick_r     <= 1'b0;
      end else if (tick_cnt_r == 32'(TICK_CYC - 1)) begin
         tick_cnt_r <= 32'h0000_0000;
         tick_r     <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
         tick_r     <= 1'b0;
      end
   end

   // Frequency sweep lives only in internal sweep; amplitude sweep only when not fixed
   assign en[0]   = (src_r == rss_pkg::RSS_SRC_SWEEP);
   assign en[1]   = (atype_r == rss_pkg::RSS_AT_LIN) | (atype_r == rss_pkg::RSS_AT_LOG);
   assign logm[0] = flog_r;
   assign logm[1] = (atype_r == rss_pkg::RSS_AT_LOG);

   // One sweep engine per channel
   for (genvar i = 0; i < 2; i++) begin : g_sweep
      logic [53:0] pct_prod;
      logic [53:0] pct_add;
      logic [27:0] nxt;
      logic        at_end;

      // Log step adds step/100000 of the present value, truncated to 1 unit
      assign pct_prod = cur_r[i] * cfg_r[i].step;
      assign pct_add  = pct_prod / {27'h000_0000, `RSS_PCT_DEN};
      assign nxt      = logm[i] ? {1'b0, cur_r[i]} + {1'b0, pct_add[26:0]}
                                : {1'b0, cur_r[i]} + {1'b0, cfg_r[i].step};
      // A zero or wrapping step would stall forever, so it ends the pass too
      assign at_end   = (nxt >= {1'b0, cfg_r[i].stop}) | (nxt[26:0] <= cur_r[i]) | nxt[27];

      // Run control, dwell counting and stepping
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            run_r[i] <= rss_pkg::RSS_RUN_STOP;
            st_r[i]  <= rss_pkg::RSS_ST_IDLE;
            // Reset value is a constant per channel, never a net
            cur_r[i] <= (i == 0) ? `RSS_RST_FSTART : `RSS_RST_ASTART;
            cnt_r[i] <= 17'h0_0000;
         end else if (!en[i]) begin
            run_r[i] <= rss_pkg::RSS_RUN_STOP;
            st_r[i]  <= rss_pkg::RSS_ST_IDLE;
         end else if (run_wr) begin
            unique case (hwdata[2*i+1 -: 2])
               2'h1, 2'h2: begin
                  run_r[i] <= rss_pkg::rss_run_t'(hwdata[2*i+1 -: 2]);
                  st_r[i]  <= rss_pkg::RSS_ST_DWELL;
                  cur_r[i] <= cfg_r[i].start;
                  cnt_r[i] <= 17'h0_0000;
               end
               default: begin
                  run_r[i] <= rss_pkg::RSS_RUN_STOP;
                  st_r[i]  <= rss_pkg::RSS_ST_IDLE;
               end
            endcase
         end else if ((st_r[i] == rss_pkg::RSS_ST_DWELL) && tick_r) begin
            if (cnt_r[i] + 17'h0_0001 >= cfg_r[i].dwell) begin
               cnt_r[i] <= 17'h0_0000;
               if (cur_r[i] == cfg_r[i].stop) begin
                  if (run_r[i] == rss_pkg::RSS_RUN_LOOP) begin
                     cur_r[i] <= cfg_r[i].start;
                  end else begin
                     run_r[i] <= rss_pkg::RSS_RUN_STOP;
                     st_r[i]  <= rss_pkg::RSS_ST_IDLE;
                  end
               end else if (at_end) begin
                  cur_r[i] <= cfg_r[i].stop;
               end else begin
                  cur_r[i] <= nxt[26:0];
               end
            end else begin
               cnt_r[i] <= cnt_r[i] + 17'h0_0001;
            end
         end
      end
   end

   // Output reference frequency and amplitude
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         freq_o     <= `RSS_RST_REFF;
         amp_o      <= 13'h03E8;
         ext_lock_o <= 1'b1;
      end else begin
         unique case (src_r)
            rss_pkg::RSS_SRC_INT:   freq_o <= reff_r;
            rss_pkg::RSS_SRC_SWEEP: freq_o <= cur_r[0];
            default:                freq_o <= ext_freq_i;
         endcase
         amp_o      <= en[1] ? cur_r[1][12:0] : afix_r[12:0];
         ext_lock_o <= (src_r == rss_pkg::RSS_SRC_EXT);
      end
   end

   // Harmonic limiter walks each order one unit per cycle toward the legal value, or drops it straight to a lower set order
   for (genvar h = 0; h < 2; h++) begin : g_harm
      logic [41:0] prod;
      logic [41:0] prod_up;
      assign prod    = heff_r[h] * freq_o;
      assign prod_up = (heff_r[h] + 15'h0001) * freq_o;
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            heff_r[h] <= 15'h0001;
         end else if (heff_r[h] > hset_r[h]) begin
            heff_r[h] <= hset_r[h];
         end else if ((prod >= {15'h0000, `RSS_FREQ_MAX}) && (heff_r[h] > 15'h0001)) begin
            heff_r[h] <= heff_r[h] - 15'h0001;
         end else if ((heff_r[h] < hset_r[h]) && (prod_up < {15'h0000, `RSS_FREQ_MAX})) begin
            heff_r[h] <= heff_r[h] + 15'h0001;
         end
      end
   end
   assign harm1_o = heff_r[0];
   assign harm2_o = heff_r[1];

   // External reference pin: three flops, level changes once the last two agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_sync_r <= 3'h0;
         ref_lvl_r  <= 1'b0;
      end else begin
         ref_sync_r <= {ref_sync_r[1:0], ext_ref_i};
         if (ref_sync_r[1] == ref_sync_r[2]) begin
            ref_lvl_r <= ref_sync_r[2];
         end
      end
   end

   // Internal oscillator; square output follows the lock source
   assign inc_prod = freq_o * `RSS_NCO_K;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_r <= 32'h0000_0000;
         ttl_o   <= 1'b0;
      end else begin
         phase_r <= phase_r + {10'h000, inc_prod[41:20]};
         ttl_o   <= ext_lock_o ? ref_lvl_r : phase_r[31];
      end
   end
   assign phase_o = phase_r[31:16];

endmodule : rss_top
`default_nettype wire

// ### dv/rss_top_assertions.sv
`include "rss_consts.svh"
`default_nettype none
module rss_top_assertions (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [26:0] freq_o,
   input wire logic [12:0] amp_o,
   input wire logic [14:0] harm1_o,
   input wire logic [14:0] harm2_o,
   input wire logic        ttl_o
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   logic        take;
   logic        lim_hit;
   logic [41:0] prod1;
   // Full-width product, so the order limit test never wraps
   assign take    = hsel && hready && htrans[1];
   assign prod1   = harm1_o * freq_o;
   assign lim_hit = prod1 >= `RSS_FREQ_MAX && harm1_o > 15'h0001;
   // Bus timing
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("hresp not OKAY");
   read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read data phase not one wait state");
   write_fast_a: assert property (take && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   // Harmonic orders: never zero; order 1 rises one unit a cycle and is lowered at or above the limit
   harm_floor_a: assert property (harm1_o != 15'h0000 && harm2_o != 15'h0000)
      else $error("harmonic order zero");
   // Rising is one unit a cycle; falling may jump straight to a lower set value
   harm_step_a: assert property (int'(harm1_o) <= int'($past(harm1_o)) + 1)
      else $error("harmonic order jumped");
   harm_lower_a: assert property (lim_hit && $stable(freq_o) |=> harm1_o < $past(harm1_o))
      else $error("harmonic order not lowered");
   // Output ranges
   freq_range_a: assert property (freq_o != 27'h000_0000 && freq_o <= `RSS_FREQ_MAX)
      else $error("frequency out of range");
   amp_range_a: assert property (amp_o != 13'h0000 && amp_o <= 13'h1388)
      else $error("amplitude out of range");
   // Main scenarios reached
   read_c: cover property (take && !hwrite);
   lower_c: cover property (lim_hit);
   ttl_c: cover property ($changed(ttl_o));
endmodule : rss_top_assertions
bind rss_top rss_top_assertions i_rss_top_assertions (
   .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
   .freq_o, .amp_o, .harm1_o, .harm2_o, .ttl_o
);
`default_nettype wire

// ### dv/test_reference_sweep_sequencer.sv
`include "rss_consts.svh"
`default_nettype none
module test_reference_sweep_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 4;
   typedef struct packed {
      logic        we;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
   } rss_row_t;
   logic        hclk       = 1'b0;
   logic        hresetn    = 1'b0;
   logic        hsel       = 1'b0;
   logic [31:0] haddr      = 32'h0000_0000;
   logic [1:0]  htrans     = 2'h0;
   logic        hwrite     = 1'b0;
   logic [31:0] hwdata     = 32'h0000_0000;
   logic        ext_ref_i  = 1'b0;
   logic [26:0] ext_freq_i = 27'h02D_C6C0;
   logic [31:0] hrdata, q;
   logic        hreadyout, hresp, ext_lock_o, ttl_o, tp;
   logic [26:0] freq_o;
   logic [12:0] amp_o;
   logic [14:0] harm1_o, harm2_o;
   logic [15:0] phase_o;
   int          err_total   = 0;
   int          checks_done = 0;
   int          tg;
   // Register rows: write flag, offset, write data, value read back
   rss_row_t    rows [15] = '{
      '{1'b0, `RSS_A_FSTART, 32'h0, 32'h000F_4240},
      '{1'b0, `RSS_A_FSTOP, 32'h0, 32'h004C_4B40},
      '{1'b0, `RSS_A_ASTART, 32'h0, 32'h0000_03E8},
      '{1'b0, `RSS_A_ASTOP, 32'h0, 32'h0000_1388},
      '{1'b0, `RSS_A_CTRL, 32'h0, 32'h0},
      '{1'b0, `RSS_A_HARM1, 32'h0, 32'h1},
      '{1'b1, `RSS_A_FSTART, 32'h0, 32'h1},
      '{1'b1, `RSS_A_FSTOP, 32'h0FFF_FFFF, 32'h0614_6580},
      '{1'b1, `RSS_A_AFIX, 32'h0, 32'h1},
      '{1'b1, `RSS_A_AFIX, 32'h0000_1770, 32'h0000_1388},
      '{1'b1, `RSS_A_HARM1, 32'h0, 32'h1},
      '{1'b1, `RSS_A_HARM2, 32'h0000_9C40, 32'h0000_7FFF},
      '{1'b1, `RSS_A_ADWELL, 32'h0003_0D40, 32'h0001_86A0},
      '{1'b1, `RSS_A_REFF, 32'h001E_8480, 32'h001E_8480},
      '{1'b1, 8'h44, 32'h5, 32'h0}
   };

   // Short tick so that dwell steps take a few cycles only
   rss_top #(.TICK_CYC(TICK)) i_rss_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_ref_i(ext_ref_i),
      .ext_freq_i(ext_freq_i), .freq_o(freq_o), .amp_o(amp_o), .harm1_o(harm1_o),
      .harm2_o(harm2_o), .ext_lock_o(ext_lock_o), .ttl_o(ttl_o), .phase_o(phase_o)
   );

   // Bus clock, 4 ns period
   always #2 hclk = ~hclk;
   // External reference square, 40 cycles a period
   always begin
      repeat (20) @(posedge hclk);
      ext_ref_i <= ~ext_ref_i;
   end

   task automatic stop_test();
      $display("Checks %0d, errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   task automatic fail_if(input bit bad);
      if (bad) begin
         err_total++;
         $display("Error wait expected done seen timeout");
         stop_test();
      end
   endtask : fail_if

   task automatic rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      fail_if(hreadyout !== 1'b1);
   endtask : rdy

   // One single AHB transfer; request held until hready is seen high
   task automatic ahb(input bit w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h00_0000, a};
      hwrite <= w;
      rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      r = hrdata;
   endtask : ahb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask : wr

   function automatic logic [26:0] val(input bit amp);
      return amp ? {14'h0000, amp_o} : freq_o;
   endfunction : val

   function automatic logic [31:0] ctrl(input rss_pkg::rss_src_t s, input logic lg,
                                        input rss_pkg::rss_atype_t t);
      return {27'h000_0000, t, lg, s};
   endfunction : ctrl

   // Largest order whose product with f stays under the limit
   function automatic int hlim(input int s, input int f);
      return (s < (`RSS_FREQ_MAX - 1) / f) ? s : (`RSS_FREQ_MAX - 1) / f;
   endfunction : hlim

   // Wait for a value, or for the next change, then compare
   task automatic see(input bit amp, input bit chg, input logic [26:0] e, output int n);
      logic [26:0] p;
      p = val(amp);
      for (n = 0; n < 100 && (chg ? val(amp) === p : val(amp) !== e); n++) begin
         @(posedge hclk);
      end
      fail_if(n == 100);
      chk("sweep_value", e, val(amp));
   endtask : see

   task automatic harm(input int s1, input int s2, input int f);
      wr(`RSS_A_HARM1, s1);
      wr(`RSS_A_HARM2, s2);
      wr(`RSS_A_REFF, f);
      repeat (300) @(posedge hclk);
      chk("harm1_o", hlim(s1, f), harm1_o);
      chk("harm2_o", hlim(s2, f), harm2_o);
      ahb(1'b0, `RSS_A_HEFF, 32'h0, q);
      chk("heff", (hlim(s2, f) << 16) | hlim(s1, f), q);
   endtask : harm

   // Runs one sweep; expected steps come from start, stop and step alone
   task automatic sweep(input bit amp, input bit lg, input longint st, sp, stp,
                        input int dw, input bit lp);
      longint      e;
      int          n;
      int          k;
      logic [26:0] v;
      logic [7:0]  b;
      b = amp ? `RSS_A_ASTART : `RSS_A_FSTART;
      wr(b, st);
      wr(b + 8'h04, sp);
      wr(b + 8'h08, stp);
      wr(b + 8'h0C, dw);
      wr(`RSS_A_RUN, (lp ? 2 : 1) << (amp ? 2 : 0));
      see(amp, 1'b0, st, n);
      e = st;
      k = 0;
      while (e != sp) begin
         e = lg ? e + e * stp / `RSS_PCT_DEN : e + stp;
         e = (e >= sp) ? sp : e;
         see(amp, 1'b1, e, n);
         k++;
         if (k > 1) begin
            chk("dwell_cycles", dw * TICK, n);
         end
      end
      if (lp) begin
         see(amp, 1'b1, st, n);
         wr(`RSS_A_RUN, 0);
      end else begin
         repeat (20) @(posedge hclk);
      end
      @(posedge hclk);
      v = val(amp);
      repeat (40) @(posedge hclk);
      chk("held_value", lp ? v : sp, val(amp));
      ahb(1'b0, `RSS_A_RUN, 32'h0, q);
      chk("run_state", 0, q);
   endtask : sweep

   // Main sequence
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      chk("freq_o", ext_freq_i, freq_o);
      chk("ext_lock_o", 1, ext_lock_o);
      tg = 0;
      tp = ttl_o;
      repeat (400) begin
         @(posedge hclk);
         tg += int'(ttl_o !== tp);
         tp = ttl_o;
      end
      chk("ttl_toggles", 1, tg inside {[19:21]});
      foreach (rows[i]) begin
         if (rows[i].we) begin
            wr(rows[i].a, rows[i].d);
         end
         ahb(1'b0, rows[i].a, 32'h0, q);
         chk("reg_read", rows[i].e, q);
      end
      wr(`RSS_A_CTRL, ctrl(rss_pkg::RSS_SRC_INT, 1'b0, rss_pkg::RSS_AT_FIXED));
      wr(`RSS_A_RUN, 1);
      repeat (30) @(posedge hclk);
      chk("freq_o", 32'h001E_8480, freq_o);
      chk("ext_lock_o", 0, ext_lock_o);
      chk("amp_o", 32'h0000_1388, amp_o);
      harm(200, 7, 2000000);
      harm(200, 7, 20000000);
      wr(`RSS_A_CTRL, ctrl(rss_pkg::RSS_SRC_SWEEP, 1'b0, rss_pkg::RSS_AT_FIXED));
      sweep(1'b0, 1'b0, 1000000, 1250000, 100000, 1, 1'b0);
      wr(`RSS_A_CTRL, ctrl(rss_pkg::RSS_SRC_SWEEP, 1'b1, rss_pkg::RSS_AT_FIXED));
      sweep(1'b0, 1'b1, 1000000, 2000000, 10000, 1, 1'b1);
      wr(`RSS_A_CTRL, ctrl(rss_pkg::RSS_SRC_INT, 1'b0, rss_pkg::RSS_AT_LIN));
      sweep(1'b1, 1'b0, 1000, 1350, 100, 2, 1'b0);
      wr(`RSS_A_CTRL, ctrl(rss_pkg::RSS_SRC_INT, 1'b0, rss_pkg::RSS_AT_LOG));
      sweep(1'b1, 1'b1, 1000, 1500, 10000, 2, 1'b1);
      // Second reset after the sweeps are stopped brings defaults back
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      chk("harm1_o", 1, harm1_o);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, `RSS_A_FSTART, 32'h0, q);
      chk("fstart", 32'h000F_4240, q);
      stop_test();
   end
endmodule : test_reference_sweep_sequencer
`default_nettype wire
